// ---- hdl/reset_strap_consts.svh ----
// Constants for the reset and strap capture block.
`ifndef RESET_STRAP_CONSTS_SVH
`define RESET_STRAP_CONSTS_SVH
`define RSM_GROUP_HI      40'h0180c20000
`define RSM_GROUP_LO_MIN  8'h03
`define RSM_GROUP_LO_MAX  8'h0f
`define RSM_MGMT_NS       1000
`define RSM_CLK_NS        40
`define RSM_MGMT_CYCLES   ((`RSM_MGMT_NS + `RSM_CLK_NS - 1) / `RSM_CLK_NS)
`endif

// ---- hdl/reset_strap_pkg.sv ----
// Types for the reset and strap capture block.
package reset_strap_pkg;
   typedef enum logic [1:0] {
      st_reset   = 2'b00,
      st_capture = 2'b01,
      st_mgmt    = 2'b11,
      st_run     = 2'b10
   } phase_type;
endpackage : reset_strap_pkg

// ---- hdl/reset_strap_mode_latch.sv ----
// Reset sequencing, strap capture and reserved-group drop decision.
//
// Contract
// (R1) While reset is low, all logic holds a defined initial state; the strap and reset sync flops have no reset and track their pins.
// (R2) On reset rising edge, sample every strap and fix the configuration.
// (R3) Start PHY management writes and autoneg restart only after capture.
// (R4) Port A force enable selects strap values, else autoneg results.
// (R5) Port A forced flow control: 1 on, 0 off.
// (R6) Port A forced duplex: 1 full, 0 half.
// (R7) Port A forced speed: 1 is 100 Mbps, 0 is 10 Mbps.
// (R8) Port B force enable selects strap values, else autoneg results.
// (R9) Port B forced flow control: 1 on, 0 off.
// (R10) Port B forced duplex: 1 full, 0 half.
// (R11) Port B forced speed: 1 is 100 Mbps, 0 is 10 Mbps.
// (R12) Storm filtering active when its strap was high at reset.
// (R13) Drop strap set: discard frames to group 01-80-C2-00-00-03..0F.
// (R14) Drop strap clear: flood those frames instead.
// (R15) Management clock and data stay high impedance during reset.
// (R16) Captured straps stay constant until the next reset.
`timescale 1ns/100ps
`default_nettype none
`include "reset_strap_consts.svh"
module reset_strap_mode_latch
   import reset_strap_pkg::*;
#(
   parameter int mgmt_cycles = `RSM_MGMT_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        port_a_force_enable_i,
   input  wire logic        port_a_force_pause_i,
   input  wire logic        port_a_force_full_i,
   input  wire logic        port_a_force_fast_i,
   input  wire logic        port_b_force_enable_i,
   input  wire logic        port_b_force_pause_i,
   input  wire logic        port_b_force_full_i,
   input  wire logic        port_b_force_fast_i,
   input  wire logic        storm_filter_enable_i,
   input  wire logic        reserved_group_drop_enable_i,
   input  wire logic        port_a_an_pause_i,
   input  wire logic        port_a_an_full_i,
   input  wire logic        port_a_an_fast_i,
   input  wire logic        port_b_an_pause_i,
   input  wire logic        port_b_an_full_i,
   input  wire logic        port_b_an_fast_i,
   input  wire logic        frame_valid_i,
   input  wire logic [47:0] frame_dest_i,
   input  wire logic        mgmt_done_i,
   output logic             sys_reset_o,
   output logic             config_valid_o,
   output logic             mgmt_start_o,
   output logic             an_restart_o,
   output logic             mgmt_active_o,
   output logic             mgmt_clk_oe_n_o,
   output logic             mgmt_data_oe_n_o,
   output logic             port_a_pause_o,
   output logic             port_a_full_o,
   output logic             port_a_fast_o,
   output logic             port_b_pause_o,
   output logic             port_b_full_o,
   output logic             port_b_fast_o,
   output logic             storm_filter_o,
   output logic             reserved_group_drop_o,
   output logic             frame_drop_o,
   output logic             frame_flood_o
);

   // Straps are board levels, so they pass two flops like any pin.
   logic [9:0] strap_meta;
   logic [9:0] strap_sync;
   logic       rst_meta;
   logic       rst_sync;
   logic [9:0] strap_latched;
   logic [9:0] next_strap_latched;
   phase_type  phase;
   phase_type  next_phase;
   logic [15:0] wait_count;
   logic [15:0] next_wait_count;
   logic       next_mgmt_start;
   logic       next_an_restart;
   logic       mgmt_start_q;
   logic       an_restart_q;
   logic       drop_q;
   logic       flood_q;
   logic       next_drop;
   logic       next_flood;
   logic       in_group;

   // The reset pin is synchronised too; the sequencer restarts on its low.
   always_ff @(posedge ref_clk_i) begin
      strap_meta <= {reserved_group_drop_enable_i, storm_filter_enable_i,
                     port_b_force_fast_i, port_b_force_full_i,
                     port_b_force_pause_i, port_b_force_enable_i,
                     port_a_force_fast_i, port_a_force_full_i,
                     port_a_force_pause_i, port_a_force_enable_i};
      strap_sync <= strap_meta;
      rst_meta   <= nrst_i;
      rst_sync   <= rst_meta;
   end

   always_comb begin
      next_phase         = phase;
      next_strap_latched = strap_latched;
      next_wait_count    = wait_count;
      next_mgmt_start    = 1'b0;
      next_an_restart    = 1'b0;
      case (phase)
         st_reset: begin
            // The sync flop sees the pin go high; the straps it carries
            // arrived through the same two stages, so both align.
            if (rst_sync) begin
               next_strap_latched = strap_sync; // R2
               next_phase         = st_capture;
            end
         end
         st_capture: begin
            // Start rises one cycle after the capture edge, so the latched
            // configuration is already visible when the PHY writes begin.
            next_mgmt_start = 1'b1; // R3
            next_wait_count = 16'(mgmt_cycles);
            next_phase      = st_mgmt;
         end
         st_mgmt: begin
            // The settle time runs before done is looked at, which gives
            // the PHYs time to leave their own reset before the restart.
            if (wait_count != 16'h0000) begin
               next_wait_count = wait_count - 16'h0001;
            end else if (mgmt_done_i) begin
               next_an_restart = 1'b1; // R3
               next_phase      = st_run;
            end
         end
         st_run: begin
            next_phase = st_run; // R16
         end
         default: begin
            next_phase = st_reset;
         end
      endcase
      // A low on the synchronised reset wins over every state, so a reset
      // in mid-run throws the whole sequence back to its start.
      if (!rst_sync) begin
         next_phase         = st_reset; // R1
         next_strap_latched = 10'h000;
         next_wait_count    = 16'h0000;
         next_mgmt_start    = 1'b0;
         next_an_restart    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         phase         <= st_reset; // R1
         strap_latched <= 10'h000;
         wait_count    <= 16'h0000;
         mgmt_start_q  <= 1'b0;
         an_restart_q  <= 1'b0;
      end else begin
         phase         <= next_phase;
         strap_latched <= next_strap_latched;
         wait_count    <= next_wait_count;
         mgmt_start_q  <= next_mgmt_start;
         an_restart_q  <= next_an_restart;
      end
   end

   // Only the last byte of the destination spans a range; the upper five
   // bytes must match the reserved group prefix exactly.
   assign in_group = (frame_dest_i[47:8] == `RSM_GROUP_HI) &&
                     (frame_dest_i[7:0] >= `RSM_GROUP_LO_MIN) &&
                     (frame_dest_i[7:0] <= `RSM_GROUP_LO_MAX);

   // Frames offered before the sequence reaches run get no verdict,
   // although the drop strap has been fixed since the capture state.
   always_comb begin
      next_drop  = 1'b0;
      next_flood = 1'b0;
      if (frame_valid_i && in_group && phase == st_run) begin
         next_drop  = strap_latched[9];  // R13
         next_flood = !strap_latched[9]; // R14
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         drop_q  <= 1'b0;
         flood_q <= 1'b0;
      end else begin
         drop_q  <= next_drop;
         flood_q <= next_flood;
      end
   end

   assign sys_reset_o      = (phase == st_reset);
   assign config_valid_o   = (phase != st_reset);
   assign mgmt_start_o     = mgmt_start_q;
   assign an_restart_o     = an_restart_q;
   assign mgmt_active_o    = (phase == st_mgmt);
   // High-Z until the sequence starts; oe low means driving.
   assign mgmt_clk_oe_n_o  = (phase == st_reset) || !nrst_i; // R15
   assign mgmt_data_oe_n_o = (phase == st_reset) || !nrst_i; // R15

   // Force bits select strap values, otherwise autoneg results pass.
   assign port_a_pause_o = strap_latched[0] ? strap_latched[1]
                                            : port_a_an_pause_i; // R4 R5
   assign port_a_full_o  = strap_latched[0] ? strap_latched[2]
                                            : port_a_an_full_i;  // R4 R6
   assign port_a_fast_o  = strap_latched[0] ? strap_latched[3]
                                            : port_a_an_fast_i;  // R4 R7
   assign port_b_pause_o = strap_latched[4] ? strap_latched[5]
                                            : port_b_an_pause_i; // R8 R9
   assign port_b_full_o  = strap_latched[4] ? strap_latched[6]
                                            : port_b_an_full_i;  // R8 R10
   assign port_b_fast_o  = strap_latched[4] ? strap_latched[7]
                                            : port_b_an_fast_i;  // R8 R11
   assign storm_filter_o        = strap_latched[8]; // R12
   assign reserved_group_drop_o = strap_latched[9];
   assign frame_drop_o          = drop_q;
   assign frame_flood_o         = flood_q;

endmodule : reset_strap_mode_latch
`default_nettype wire

// ---- verification/reset_strap_mode_latch_assertions.sv ----
// Checker for the reset and strap capture block.
`timescale 1ns/100ps
`default_nettype none
module reset_strap_mode_latch_checker (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic sys_reset_o,
   input wire logic config_valid_o,
   input wire logic mgmt_start_o,
   input wire logic an_restart_o,
   input wire logic mgmt_clk_oe_n_o,
   input wire logic mgmt_data_oe_n_o,
   input wire logic frame_drop_o,
   input wire logic frame_flood_o,
   input wire logic reserved_group_drop_o,
   input wire logic storm_filter_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_reset_state: assert property ($rose(nrst_i) |-> sys_reset_o)
      else $error("no reset state");
   a_pins_float: assert property ($rose(nrst_i) |-> mgmt_clk_oe_n_o &&
      mgmt_data_oe_n_o) else $error("pins driven in reset");
   a_capture_soon: assert property ($rose(nrst_i) |->
      ##[1:6] config_valid_o) else $error("straps not captured");
   a_start_after: assert property (mgmt_start_o |->
      $past(config_valid_o) ##1 !mgmt_start_o) else $error("early start");
   a_restart_due: assert property (mgmt_start_o |->
      ##[1:300] an_restart_o) else $error("no restart");
   a_drop_set: assert property (frame_drop_o |->
      reserved_group_drop_o && !frame_flood_o) else $error("bad drop");
   a_flood_clear: assert property (frame_flood_o |->
      !reserved_group_drop_o && config_valid_o) else $error("bad flood");
   a_straps_fixed: assert property (config_valid_o &&
      $past(config_valid_o) |-> $stable(reserved_group_drop_o) &&
      $stable(storm_filter_o))
      else $error("strap value moved");
   cover property (frame_drop_o);
   cover property (frame_flood_o);
   cover property (an_restart_o);
endmodule : reset_strap_mode_latch_checker
bind reset_strap_mode_latch reset_strap_mode_latch_checker chk (
   .ref_clk_i             (ref_clk_i),
   .nrst_i                (nrst_i),
   .sys_reset_o           (sys_reset_o),
   .config_valid_o        (config_valid_o),
   .mgmt_start_o          (mgmt_start_o),
   .an_restart_o          (an_restart_o),
   .mgmt_clk_oe_n_o       (mgmt_clk_oe_n_o),
   .mgmt_data_oe_n_o      (mgmt_data_oe_n_o),
   .frame_drop_o          (frame_drop_o),
   .frame_flood_o         (frame_flood_o),
   .reserved_group_drop_o (reserved_group_drop_o),
   .storm_filter_o        (storm_filter_o)
);
`default_nettype wire

// ---- verification/phy_mgmt_model.sv ----
// PHY management partner: reports done a set delay after each start.
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_model (
   input wire logic       ref_clk_i,
   input wire logic       start_i,
   input wire logic [7:0] delay_i,
   output logic           done_o
);
   // Idle value keeps done low until a start, so no answer comes unasked.
   logic [8:0] cnt = 9'h100;
   always @(posedge ref_clk_i)
      if (start_i) cnt <= {1'b0, delay_i};
      else if (cnt[7:0] != 8'h00) cnt <= cnt - 9'h001;
   assign done_o = cnt == 9'h000;
endmodule : phy_mgmt_model
`default_nettype wire

// ---- verification/reset_strap_mode_latch_tb_top.sv ----
// Self-checking bench for the reset and strap capture block.
`timescale 1ns/100ps
`default_nettype none
module reset_strap_mode_latch_tb_top;
   logic clk = 1'b0, nrst = 1'b0, fv = 1'b0;
   logic [9:0] s = 10'h000;
   logic [5:0] an = 6'h29;
   logic [7:0] dl = 8'h00;
   logic [47:0] d = 48'h0;
   wire [17:0] o;
   int errors = 0, total_checks = 0, cycles = 0;
   reset_strap_mode_latch #(.mgmt_cycles(2)) dut (.ref_clk_i(clk),
      .nrst_i(nrst), .port_a_force_enable_i(s[9]),
      .port_a_force_pause_i(s[8]), .port_a_force_full_i(s[7]),
      .port_a_force_fast_i(s[6]), .port_b_force_enable_i(s[5]),
      .port_b_force_pause_i(s[4]), .port_b_force_full_i(s[3]),
      .port_b_force_fast_i(s[2]), .storm_filter_enable_i(s[1]),
      .reserved_group_drop_enable_i(s[0]), .port_a_an_pause_i(an[5]),
      .port_a_an_full_i(an[4]), .port_a_an_fast_i(an[3]),
      .port_b_an_pause_i(an[2]), .port_b_an_full_i(an[1]),
      .port_b_an_fast_i(an[0]), .frame_valid_i(fv), .frame_dest_i(d),
      .mgmt_done_i(o[17]), .sys_reset_o(o[0]), .config_valid_o(o[1]),
      .mgmt_start_o(o[2]), .an_restart_o(o[3]), .mgmt_active_o(o[4]),
      .mgmt_clk_oe_n_o(o[5]), .mgmt_data_oe_n_o(o[6]),
      .port_a_pause_o(o[14]), .port_a_full_o(o[13]), .port_a_fast_o(o[12]),
      .port_b_pause_o(o[11]), .port_b_full_o(o[10]), .port_b_fast_o(o[9]),
      .storm_filter_o(o[8]), .reserved_group_drop_o(o[7]),
      .frame_drop_o(o[15]), .frame_flood_o(o[16]));
   phy_mgmt_model phy (.ref_clk_i(clk), .start_i(o[2]), .delay_i(dl),
      .done_o(o[17]));
   always #20 clk = ~clk;
   always @(posedge clk) if (cycles++ == 3000) close_out(1);
   task automatic chk(input string n, input logic [7:0] e, g);
      total_checks++;
      errors += (g !== e);
      if (g !== e) $display("FAIL %s expected %h seen %h", n, e, g);
   endtask : chk
   task automatic boot(input logic [9:0] v, input logic [7:0] t);
      {nrst, s, dl} <= {1'b0, v, t};
      repeat (10) @(posedge clk);
      chk("reset", 8'h61, {1'b0, o[6:0]});
      nrst <= 1'b1;
      repeat (4) @(negedge clk);
      chk("capture", 8'h02, {1'b0, o[6:0]});
      @(negedge clk);
      chk("start", 8'h16, {1'b0, o[6:0]});
      repeat (300) @(negedge clk) if (o[3] === 1'b1) break;
      chk("restart", 8'h0a, {1'b0, o[6:0]});
      @(posedge clk);
   endtask : boot
   // Each entry: straps, then outputs before and after the pins move.
   task automatic t_config();
      logic [25:0] v [3] = '{26'h36aaaaa, 26'h2b55555, 26'h1dca458};
      foreach (v[i]) begin
         boot(v[i][25:16], 8'(i * 20));
         chk("config", v[i][15:8], o[14:7]);
         {s, an} <= {~v[i][25:16], ~an};
         repeat (4) @(posedge clk);
         chk("held", v[i][7:0], o[14:7]);
      end
      $display("config done");
   endtask : t_config
   task automatic t_frames();
      logic [10:0] f [5] = '{11'h40d, 11'h43d, 11'h440, 11'h00e, 11'h008};
      foreach (f[i]) begin
         if (i % 3 == 0) boot({9'h000, f[i][10]}, 8'h05);
         {fv, d} <= {1'b1, 40'h0180c20000, f[i][9:2]};
         @(posedge clk);
         fv <= 1'b0;
         @(negedge clk);
         chk("frame", {6'h00, f[i][1:0]}, {6'h00, o[16:15]});
         @(posedge clk);
      end
      $display("frames done");
   endtask : t_frames
   task automatic close_out(input int late);
      errors += late;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial begin
      t_config();
      t_frames();
      close_out(0);
   end
endmodule : reset_strap_mode_latch_tb_top
`default_nettype wire
